// ==== esa_bit_if.sv ====
// received bit stream and line monitor results between the block's modules
`timescale 1ns/1ps
`default_nettype none
interface esa_bit_if;
   logic bit_stb;
   logic bit_val;
   logic t1_mode;
   logic alt_crit;
   logic los;
   logic ua1;
   modport src  (output bit_stb, output bit_val, output t1_mode, output alt_crit,
                 input los, input ua1);
   modport sink (input bit_stb, input bit_val, input t1_mode, input alt_crit,
                 output los, output ua1);
endinterface
`default_nettype wire

// ==== esa_consts.svh ====
// offsets, field positions, reset values and counts of the e1 sync/alarm block
`ifndef ESA_CONSTS_SVH
`define ESA_CONSTS_SVH
// ----------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------
`define ESA_IDX_IDENT   6'h10
`define ESA_IDX_RESYNC  6'h12
`define ESA_IDX_LINE    6'h13
`define ESA_IDX_STATUS  6'h16
`define ESA_IDX_MASK    6'h17
`define ESA_IDX_SEARCH  6'h1C
`define ESA_IDX_RXCTL   6'h1D
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ESA_RXCTL_RESYNC 0
`define ESA_RXCTL_ALT    6
`define ESA_RXCTL_WMASK  8'h41
`define ESA_MASK_RST     8'h00
`define ESA_RXCTL_RST    8'h00
// ----------------------------------------
// counts
// ----------------------------------------
`define ESA_FAS_ERR_RUN  2'h3
`define ESA_CAS_ERR_RUN  2'h2
`define ESA_CRC_WINDOW   10'h3E8
`define ESA_CRC_ERR_MIN  10'h393
`define ESA_LOS_E1       12'h0FF
`define ESA_LOS_ALT      12'h800
`define ESA_LOS_T1       12'h0C0
`define ESA_LOS_WIN_E1   8'hFF
`define ESA_LOS_ONES_E1  8'h20
`define ESA_LOS_WIN_T1   8'h70
`define ESA_LOS_ONES_T1  8'h0E
`define ESA_UA1_ZERO_MIN 2'h3
`endif

// ==== esa_line_mon.sv ====
// loss-of-signal and unframed all-ones detector on the received bit stream
`timescale 1ns/1ps
`default_nettype none
`include "esa_consts.svh"
module esa_line_mon #(
   parameter int CNT_W = 12
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   esa_bit_if.sink  bus
);
   generate
      if (CNT_W < 12) begin : g_bad_w
         $error("esa_line_mon: CNT_W must hold 2048");
      end
   endgenerate

   // ----------------------------------------
   // loss of signal
   // ----------------------------------------
   logic [CNT_W-1:0] zr_q;
   logic [7:0]       win_q;
   logic [7:0]       ones_q;
   logic             los_q;
   logic [8:0]       uwin_q;
   logic [1:0]       uz_q;
   logic             ua_q;

   wire logic [CNT_W-1:0] thr = bus.t1_mode ? CNT_W'(`ESA_LOS_T1) :
                                (bus.alt_crit ? CNT_W'(`ESA_LOS_ALT) : CNT_W'(`ESA_LOS_E1));
   wire logic [CNT_W-1:0] zr_d = bus.bit_val ? '0 : ((&zr_q) ? zr_q : zr_q + CNT_W'(1));
   wire logic los_set = bus.bit_stb & ~bus.bit_val & (zr_d >= thr);
   wire logic [7:0] win_len = bus.t1_mode ? `ESA_LOS_WIN_T1 : `ESA_LOS_WIN_E1;
   wire logic [7:0] ones_min = bus.t1_mode ? `ESA_LOS_ONES_T1 : `ESA_LOS_ONES_E1;
   wire logic win_end = bus.bit_stb & (win_q == win_len - 8'h01);
   wire logic [7:0] ones_d = ones_q + {7'h00, bus.bit_val};
   // fixed windows, not sliding: clearing may take up to two windows
   wire logic los_clr = win_end & (ones_d >= ones_min);

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         zr_q   <= '0;
         win_q  <= 8'h00;
         ones_q <= 8'h00;
         los_q  <= 1'b0;
      end else if (bus.bit_stb) begin
         zr_q   <= zr_d;
         win_q  <= win_end ? 8'h00 : win_q + 8'h01;
         ones_q <= win_end ? 8'h00 : ones_d;
         los_q  <= los_set | (los_q & ~los_clr);
      end
   end

   // ----------------------------------------
   // unframed all ones over 512 bits
   // ----------------------------------------
   wire logic ua_end = bus.bit_stb & (&uwin_q);
   wire logic [1:0] uz_d = (~bus.bit_val & (uz_q != 2'h3)) ? uz_q + 2'h1 : uz_q;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         uwin_q <= 9'h000;
         uz_q   <= 2'h0;
         ua_q   <= 1'b0;
      end else if (bus.bit_stb) begin
         uwin_q <= uwin_q + 9'h001;
         uz_q   <= ua_end ? 2'h0 : uz_d;
         if (ua_end) begin
            ua_q <= (uz_d < `ESA_UA1_ZERO_MIN);
         end
      end
   end

   assign bus.los = los_q;
   assign bus.ua1 = ua_q;

   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   a_los_set_run:  assert property (los_set |=> los_q) else $error("los not set");
   a_los_clr_win:  assert property (win_end & los_clr & ~los_set |=> !los_q) else $error("los not cleared");
   a_ua1_decide:   assert property (ua_end |=> ua_q == ($past(uz_d) < 2'h3)) else $error("ua1 wrong");
   c_los_seen:     cover property (los_set ##1 los_q);
endmodule
`default_nettype wire

// ==== esa_pkg.sv ====
// types shared by the e1 sync/alarm block
package esa_pkg;
   typedef logic [7:0] esa_byte_t;
   typedef logic [3:0] esa_nib_t;
endpackage

// ==== esa_sync_alarm.sv ====
// e1 receive synchronizer event, search and line alarm status block
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "esa_consts.svh"
module esa_sync_alarm #(
   parameter logic [3:0] REVISION  = 4'h3,  // arbitrary value
   parameter logic [3:0] PART_CODE = 4'h9,  // arbitrary value
   parameter int         LOS_CNT_W = 12
) (
   input  wire logic       mclk_in,
   input  wire logic       rst_n_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   input  wire logic       rx_bit_stb_in,
   input  wire logic       rx_bit_in,
   input  wire logic       nfas_bit3_stb_in,
   input  wire logic       sa7_stb_in,
   input  wire logic       ts16_bit6_stb_in,
   input  wire logic       fas_word_stb_in,
   input  wire logic       fas_word_err_in,
   input  wire logic       cas_mfaw_stb_in,
   input  wire logic       cas_mfaw_err_in,
   input  wire logic       crc_word_stb_in,
   input  wire logic       crc_word_err_in,
   input  wire logic       fas_search_in,
   input  wire logic       cas_search_in,
   input  wire logic       crc_search_in,
   input  wire logic       crc_search_timeout_in,
   input  wire logic       crc_sync_in,
   input  wire logic       frame_sync_in,
   input  wire logic       crc4_en_in,
   input  wire logic       t1_mode_in,
   input  wire logic       t1_yellow_in,
   output logic            resync_req_out,
   output logic            lof_out,
   output logic            los_out,
   output logic            ais_out,
   output logic            irq_out
);
   // ----------------------------------------
   // register decode
   // ----------------------------------------
   wire logic [5:0] idx     = addr_in[7:2];
   wire logic       lane_ok = (addr_in[1:0] == 2'h0);
   wire logic sel_ident  = lane_ok & (idx == `ESA_IDX_IDENT);
   wire logic sel_resync = lane_ok & (idx == `ESA_IDX_RESYNC);
   wire logic sel_line   = lane_ok & (idx == `ESA_IDX_LINE);
   wire logic sel_status = lane_ok & (idx == `ESA_IDX_STATUS);
   wire logic sel_mask   = lane_ok & (idx == `ESA_IDX_MASK);
   wire logic sel_search = lane_ok & (idx == `ESA_IDX_SEARCH);
   wire logic sel_rxctl  = lane_ok & (idx == `ESA_IDX_RXCTL);
   wire logic rd_resync  = rd_in & sel_resync;
   wire logic rd_status  = rd_in & sel_status;

   esa_pkg::esa_byte_t mask_q;
   esa_pkg::esa_byte_t rxctl_q;
   esa_pkg::esa_byte_t rdata_q;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         mask_q  <= `ESA_MASK_RST;
         rxctl_q <= `ESA_RXCTL_RST;
      end else if (wr_in) begin
         if (sel_mask) begin
            mask_q <= wdata_in;
         end
         if (sel_rxctl) begin
            rxctl_q <= wdata_in & `ESA_RXCTL_WMASK;
         end
      end
   end

   // ----------------------------------------
   // resync criteria
   // ----------------------------------------
   logic [1:0] fas_run_q;
   logic [1:0] cas_run_q;
   logic [9:0] crc_cnt_q;
   logic [9:0] crc_err_q;

   wire logic fas_hit = fas_word_stb_in & fas_word_err_in &
                        (fas_run_q == `ESA_FAS_ERR_RUN - 2'h1);
   wire logic cas_hit = cas_mfaw_stb_in & cas_mfaw_err_in &
                        (cas_run_q == `ESA_CAS_ERR_RUN - 2'h1);
   wire logic crc_last = crc_word_stb_in & (crc_cnt_q == `ESA_CRC_WINDOW - 10'h001);
   wire logic [9:0] crc_err_d = crc_err_q + {9'h000, crc_word_err_in};
   wire logic crc_hit = crc_last & (crc_err_d >= `ESA_CRC_ERR_MIN);
   wire logic [2:0] rs_set = {crc_hit, fas_hit, cas_hit};

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         fas_run_q <= 2'h0;
         cas_run_q <= 2'h0;
         crc_cnt_q <= 10'h000;
         crc_err_q <= 10'h000;
      end else begin
         if (fas_word_stb_in) begin
            fas_run_q <= (fas_hit | ~fas_word_err_in) ? 2'h0 : fas_run_q + 2'h1;
         end
         if (cas_mfaw_stb_in) begin
            cas_run_q <= (cas_hit | ~cas_mfaw_err_in) ? 2'h0 : cas_run_q + 2'h1;
         end
         if (crc_word_stb_in) begin
            crc_cnt_q <= crc_last ? 10'h000 : crc_cnt_q + 10'h001;
            crc_err_q <= crc_last ? 10'h000 : crc_err_d;
         end
      end
   end

   // a new event in the read cycle survives the read
   logic [2:0] resync_q;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         resync_q <= 3'h0;
      end else begin
         resync_q <= (resync_q & ~{3{rd_resync}}) | rs_set;
      end
   end

   // ----------------------------------------
   // manual resync and loss of frame
   // ----------------------------------------
   logic resync_prev_q;
   logic resync_req_q;
   logic lof_q;
   wire logic manual = rxctl_q[`ESA_RXCTL_RESYNC] & ~resync_prev_q;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         resync_prev_q <= 1'b0;
         resync_req_q  <= 1'b0;
         lof_q         <= 1'b1;
      end else begin
         resync_prev_q <= rxctl_q[`ESA_RXCTL_RESYNC];
         resync_req_q  <= manual;
         if (manual | (|rs_set)) begin
            lof_q <= 1'b1;
         end else if (frame_sync_in) begin
            lof_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // search flags and crc4 search counter
   // ----------------------------------------
   logic [2:0] search_q;
   logic [5:0] csc_q;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         search_q <= 3'h0;
         csc_q    <= 6'h00;
      end else begin
         search_q <= {fas_search_in, cas_search_in, crc_search_in};
         if (crc_sync_in | ~crc4_en_in) begin
            csc_q <= 6'h00;
         end else if (crc_search_timeout_in) begin
            csc_q <= csc_q + 6'h01;
         end
      end
   end

   // ----------------------------------------
   // time slot 0 / 16 alarms
   // ----------------------------------------
   logic [2:0] rra_h_q;
   logic [2:0] sa7_h_q;
   logic       dma_prev_q;
   logic       rra_q;
   logic       dma_q;
   logic       v52_q;
   wire logic [2:0] rra_h_d = {rra_h_q[1:0], rx_bit_in};
   wire logic [2:0] sa7_h_d = {sa7_h_q[1:0], rx_bit_in};
   wire logic [1:0] sa7_z = {1'b0, ~sa7_h_d[0]} + {1'b0, ~sa7_h_d[1]} + {1'b0, ~sa7_h_d[2]};

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         rra_h_q    <= 3'h0;
         sa7_h_q    <= 3'h7;
         dma_prev_q <= 1'b0;
         rra_q      <= 1'b0;
         dma_q      <= 1'b0;
         v52_q      <= 1'b0;
      end else begin
         if (nfas_bit3_stb_in) begin
            rra_h_q <= rra_h_d;
            if (rra_h_d == 3'h7) begin
               rra_q <= 1'b1;
            end else if (rra_h_d == 3'h0) begin
               rra_q <= 1'b0;
            end
         end
         if (sa7_stb_in) begin
            sa7_h_q <= sa7_h_d;
            v52_q   <= (sa7_z >= 2'h2);
         end
         if (ts16_bit6_stb_in) begin
            dma_prev_q <= rx_bit_in;
            dma_q      <= dma_prev_q & rx_bit_in;
         end
      end
   end

   // ----------------------------------------
   // line monitor
   // ----------------------------------------
   esa_bit_if u_bit ();
   assign u_bit.bit_stb  = rx_bit_stb_in;
   assign u_bit.bit_val  = rx_bit_in;
   assign u_bit.t1_mode  = t1_mode_in;
   assign u_bit.alt_crit = rxctl_q[`ESA_RXCTL_ALT];

   esa_line_mon #(
      .CNT_W (LOS_CNT_W)
   ) u_mon (
      .mclk_in  (mclk_in),
      .rst_n_in (rst_n_in),
      .bus      (u_bit.sink)
   );

   // ----------------------------------------
   // alarm status, clear events, interrupt
   // ----------------------------------------
   esa_pkg::esa_nib_t cond_q;
   esa_pkg::esa_nib_t prev_q;
   esa_pkg::esa_nib_t clr_ev_q;
   esa_pkg::esa_nib_t pend_q;
   logic              irq_q;
   wire esa_pkg::esa_nib_t rise = cond_q & ~prev_q;
   wire esa_pkg::esa_nib_t fall = prev_q & ~cond_q;
   wire logic irq_d = (|(pend_q & mask_q[3:0])) | (|(clr_ev_q & mask_q[7:4]));

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         cond_q   <= 4'h0;
         prev_q   <= 4'h0;
         clr_ev_q <= 4'h0;
         pend_q   <= 4'h0;
         irq_q    <= 1'b0;
      end else begin
         cond_q   <= {t1_mode_in & t1_yellow_in, u_bit.ua1, u_bit.los, lof_q};
         prev_q   <= cond_q;
         clr_ev_q <= (clr_ev_q & ~{4{rd_status}}) | fall;
         pend_q   <= (pend_q & ~{4{rd_status}}) | rise;
         irq_q    <= irq_d;
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   wire esa_pkg::esa_byte_t rd_val =
      sel_ident  ? {PART_CODE, REVISION} :
      sel_resync ? {5'h00, resync_q} :
      sel_line   ? {4'h0, v52_q, dma_q, cond_q[2], rra_q} :
      sel_status ? {clr_ev_q, cond_q} :
      sel_mask   ? mask_q :
      sel_search ? {csc_q[5:2], csc_q[0], search_q} :
      sel_rxctl  ? rxctl_q : 8'h00;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rd_in ? rd_val : 8'h00;
      end
   end

   assign rdata_out      = rdata_q;
   assign resync_req_out = resync_req_q;
   assign lof_out        = cond_q[0];
   assign los_out        = cond_q[1];
   assign ais_out        = cond_q[2];
   assign irq_out        = irq_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   a_cas_event_latch: assert property (cas_hit |=> resync_q[0]) else $error("cas event lost");
   a_fas_event_latch: assert property (fas_hit |=> resync_q[1]) else $error("fas event lost");
   a_crc_event_latch: assert property (crc_hit |=> resync_q[2]) else $error("crc event lost");
   a_search_live:     assert property (1'b1 |=> search_q ==
                         $past({fas_search_in, cas_search_in, crc_search_in}))
                         else $error("search flags stale");
   a_csc_step:        assert property (crc_search_timeout_in & crc4_en_in & ~crc_sync_in
                         |=> csc_q == $past(csc_q) + 6'h01) else $error("counter no step");
   a_csc_clear:       assert property (crc_sync_in | ~crc4_en_in |=> csc_q == 6'h00)
                         else $error("counter not cleared");
   a_lof_raise:       assert property (manual | (|rs_set) |=> lof_q ##1 cond_q[0])
                         else $error("lof not raised");
   a_resync_pulse:    assert property (resync_req_out |=> !resync_req_out)
                         else $error("resync request too long");
   a_ident_read:      assert property (rd_in & sel_ident |=> rdata_out == {PART_CODE, REVISION})
                         else $error("ident wrong");
   a_lof_clear_ev:    assert property ($fell(cond_q[0]) |=> clr_ev_q[0])
                         else $error("lof clear event lost");
   a_rd_clears:       assert property (rd_resync |=> resync_q == $past(rs_set))
                         else $error("read did not clear");
   a_irq_masked:      assert property ((mask_q == 8'h00) [*2] |-> !irq_out)
                         else $error("masked interrupt seen");

   c_lof_cleared:     cover property (cond_q[0] ##1 !cond_q[0]);
   c_crc_event:       cover property (crc_hit);
   c_irq_fired:       cover property (!irq_out ##1 irq_out);
   c_manual_resync:   cover property (manual ##1 lof_q);
endmodule
`default_nettype wire

// ==== test_e1_sync_alarm_status.sv ====
// self-checking bench for the e1 sync/alarm status block
`timescale 1ns/1ps
`default_nettype none
`include "esa_consts.svh"
module test_e1_sync_alarm_status;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   localparam logic [3:0] REV  = 4'h5;  // arbitrary value
   localparam logic [3:0] PART = 4'hA;  // arbitrary value
   localparam logic [7:0] A_ID = {`ESA_IDX_IDENT, 2'b00};
   localparam logic [7:0] A_RS = {`ESA_IDX_RESYNC, 2'b00};
   localparam logic [7:0] A_LN = {`ESA_IDX_LINE, 2'b00};
   localparam logic [7:0] A_ST = {`ESA_IDX_STATUS, 2'b00};
   localparam logic [7:0] A_MK = {`ESA_IDX_MASK, 2'b00};
   localparam logic [7:0] A_SR = {`ESA_IDX_SEARCH, 2'b00};
   localparam logic [7:0] A_RC = {`ESA_IDX_RXCTL, 2'b00};
   logic       mclk_in;
   logic       rst_n_in;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic [9:0] stb;
   logic       val;
   logic [2:0] search;
   logic       crc4_en;
   logic       t1_mode;
   logic       t1_yellow;
   logic       resync_req;
   logic       lof;
   logic       los;
   logic       ais;
   logic       irq;
   int         n_fail;
   int         comparisons;
   int         cycles;

   esa_sync_alarm #(.REVISION(REV), .PART_CODE(PART), .LOS_CNT_W(12)) i_dut (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .rx_bit_stb_in(stb[0]), .rx_bit_in(val),
      .nfas_bit3_stb_in(stb[1]), .sa7_stb_in(stb[2]), .ts16_bit6_stb_in(stb[3]),
      .fas_word_stb_in(stb[4]), .fas_word_err_in(val), .cas_mfaw_stb_in(stb[5]),
      .cas_mfaw_err_in(val), .crc_word_stb_in(stb[6]), .crc_word_err_in(val),
      .fas_search_in(search[2]), .cas_search_in(search[1]), .crc_search_in(search[0]),
      .crc_search_timeout_in(stb[7]), .crc_sync_in(stb[9]), .frame_sync_in(stb[8]),
      .crc4_en_in(crc4_en), .t1_mode_in(t1_mode), .t1_yellow_in(t1_yellow),
      .resync_req_out(resync_req), .lof_out(lof), .los_out(los), .ais_out(ais), .irq_out(irq));

   // ----------------------------------------
   // bus and check tasks
   // ----------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge mclk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_in);
      rd <= 1'b0;
      #1 chk(name, rdata, exp);
      // return on an edge so the caller's next drive lands there
      @(posedge mclk_in);
   endtask
   // strobes are spaced a cycle apart so no strobe is driven twice at one edge
   task automatic pulse(input int k, input logic v, input int n);
      repeat (n) begin
         @(posedge mclk_in);
         stb[k] <= 1'b1;
         val <= v;
         @(posedge mclk_in);
         stb[k] <= 1'b0;
      end
   endtask
   task automatic req_count(input logic [7:0] exp);
      int c;
      c = 0;
      repeat (6) begin
         @(posedge mclk_in);
         #1;
         if (resync_req === 1'b1) c++;
      end
      chk("resync_req", 8'(c), exp);
   endtask

   // ----------------------------------------
   // clock, timeout, sequence
   // ----------------------------------------
   initial begin
      mclk_in = 1'b0;
      forever #2 mclk_in = ~mclk_in;
   end
   // the full sequence needs about 17000 cycles
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 40000) begin
         n_fail++;
         close_out();
      end
   end
   initial begin
      {addr, wdata, wr, rd, stb, val, search, crc4_en, t1_mode, t1_yellow} = '0;
      rst_n_in = 1'b0;
      n_fail = 0;
      comparisons = 0;
      repeat (2) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      tick(3);
      chk("irq", {7'h00, irq}, 8'h00);
      rd_reg(A_ST, 8'h01, "status");
      rd_reg(A_RS, 8'h00, "rst");
      rd_reg(A_MK, 8'h00, "rst");
      rd_reg(A_SR, 8'h00, "rst");
      rd_reg(A_RC, 8'h00, "rst");
      wr_reg(A_ID, 8'hFF);
      rd_reg(A_ID, {PART, REV}, "ident");
      rd_reg(8'h04, 8'h00, "unmapped");
      rd_reg(A_ID | 8'h01, 8'h00, "misaligned");
      wr_reg(A_MK, 8'hA5);
      rd_reg(A_MK, 8'hA5, "mask");
      wr_reg(A_MK, 8'h00);
      // frame sync, then manual resync
      pulse(8, 1'b1, 1);
      tick(3);
      chk("lof", {7'h00, lof}, 8'h00);
      rd_reg(A_ST, 8'h10, "status");
      rd_reg(A_ST, 8'h00, "status");
      wr_reg(A_RC, 8'h01);
      req_count(8'h01);
      chk("lof", {7'h00, lof}, 8'h01);
      wr_reg(A_RC, 8'h01);
      req_count(8'h00);
      // resync criteria
      pulse(4, 1'b1, 2);
      pulse(4, 1'b0, 1);
      pulse(4, 1'b1, 2);
      rd_reg(A_RS, 8'h00, "resync");
      pulse(4, 1'b1, 1);
      rd_reg(A_RS, 8'h02, "resync");
      rd_reg(A_RS, 8'h00, "resync");
      pulse(5, 1'b1, 1);
      pulse(5, 1'b0, 1);
      pulse(5, 1'b1, 1);
      rd_reg(A_RS, 8'h00, "resync");
      pulse(5, 1'b1, 1);
      rd_reg(A_RS, 8'h01, "resync");
      pulse(6, 1'b1, 914);
      pulse(6, 1'b0, 86);
      rd_reg(A_RS, 8'h00, "resync");
      pulse(6, 1'b0, 85);
      pulse(6, 1'b1, 915);
      rd_reg(A_RS, 8'h04, "resync");
      // live search flags and the search counter
      search <= 3'b101;
      rd_reg(A_SR, 8'h05, "search");
      search <= 3'b010;
      rd_reg(A_SR, 8'h02, "search");
      search <= 3'b000;
      crc4_en <= 1'b1;
      pulse(7, 1'b1, 5);
      rd_reg(A_SR, 8'h18, "search");
      pulse(7, 1'b1, 45);
      rd_reg(A_SR, 8'hC0, "search");
      pulse(7, 1'b1, 16);
      rd_reg(A_SR, 8'h00, "search");
      pulse(7, 1'b1, 1);
      rd_reg(A_SR, 8'h08, "search");
      pulse(9, 1'b1, 1);
      rd_reg(A_SR, 8'h00, "search");
      pulse(7, 1'b1, 4);
      rd_reg(A_SR, 8'h10, "search");
      crc4_en <= 1'b0;
      rd_reg(A_SR, 8'h00, "search");
      // signal loss: e1, alternate, t1
      pulse(0, 1'b0, 254);
      tick(4);
      chk("los", {7'h00, los}, 8'h00);
      pulse(0, 1'b0, 1);
      tick(4);
      chk("los", {7'h00, los}, 8'h01);
      pulse(0, 1'b1, 510);
      tick(4);
      chk("los", {7'h00, los}, 8'h00);
      rd_reg(A_ST, 8'h21, "status");
      wr_reg(A_RC, 8'h40);
      pulse(0, 1'b0, 2047);
      tick(4);
      chk("los", {7'h00, los}, 8'h00);
      pulse(0, 1'b0, 1);
      tick(4);
      chk("los", {7'h00, los}, 8'h01);
      pulse(0, 1'b1, 510);
      rd_reg(A_ST, 8'h21, "status");
      t1_mode <= 1'b1;
      wr_reg(A_RC, 8'h00);
      pulse(0, 1'b0, 191);
      tick(4);
      chk("los", {7'h00, los}, 8'h00);
      pulse(0, 1'b0, 1);
      tick(4);
      chk("los", {7'h00, los}, 8'h01);
      pulse(0, 1'b1, 224);
      t1_mode <= 1'b0;
      rd_reg(A_ST, 8'h21, "status");
      // unframed all-ones, then yellow
      pulse(0, 1'b1, 1536);
      tick(4);
      chk("ais", {7'h00, ais}, 8'h01);
      repeat (16) begin
         pulse(0, 1'b0, 1);
         pulse(0, 1'b1, 63);
      end
      tick(4);
      chk("ais", {7'h00, ais}, 8'h00);
      rd_reg(A_ST, 8'h41, "status");
      t1_yellow <= 1'b1;
      rd_reg(A_ST, 8'h01, "status");
      t1_mode <= 1'b1;
      rd_reg(A_ST, 8'h09, "status");
      t1_yellow <= 1'b0;
      // clear event lands a cycle after the condition falls
      tick(1);
      rd_reg(A_ST, 8'h81, "status");
      t1_mode <= 1'b0;
      // line information alarms
      pulse(1, 1'b1, 2);
      rd_reg(A_LN, 8'h00, "line");
      pulse(1, 1'b1, 1);
      rd_reg(A_LN, 8'h01, "line");
      pulse(1, 1'b0, 2);
      rd_reg(A_LN, 8'h01, "line");
      pulse(1, 1'b0, 1);
      rd_reg(A_LN, 8'h00, "line");
      pulse(3, 1'b1, 1);
      rd_reg(A_LN, 8'h00, "line");
      pulse(3, 1'b1, 1);
      rd_reg(A_LN, 8'h04, "line");
      pulse(3, 1'b0, 1);
      pulse(2, 1'b0, 1);
      rd_reg(A_LN, 8'h00, "line");
      pulse(2, 1'b1, 1);
      pulse(2, 1'b0, 1);
      rd_reg(A_LN, 8'h08, "line");
      pulse(2, 1'b1, 2);
      rd_reg(A_LN, 8'h00, "line");
      // interrupt masking
      rd_reg(A_ST, 8'h01, "status");
      tick(3);
      chk("irq", {7'h00, irq}, 8'h00);
      wr_reg(A_MK, 8'h10);
      pulse(8, 1'b1, 1);
      tick(4);
      chk("irq", {7'h00, irq}, 8'h01);
      rd_reg(A_ST, 8'h10, "status");
      tick(3);
      chk("irq", {7'h00, irq}, 8'h00);
      wr_reg(A_MK, 8'h01);
      wr_reg(A_RC, 8'h01);
      tick(6);
      chk("irq", {7'h00, irq}, 8'h01);
      rd_reg(A_ST, 8'h01, "status");
      tick(3);
      chk("irq", {7'h00, irq}, 8'h00);
      close_out();
   end
endmodule
`default_nettype wire
